// *** common/t8c_pkg.sv ***
`default_nettype none
package t8c_pkg;
	// Word byte addresses, per channel block of 0x20
	localparam logic [7:0] T8C_CH_STRIDE = 8'h20;
	localparam logic [4:0] T8C_OFS_CTRL = 5'h00;
	localparam logic [4:0] T8C_OFS_CSR = 5'h04;
	localparam logic [4:0] T8C_OFS_TCA = 5'h08;
	localparam logic [4:0] T8C_OFS_TCB = 5'h0c;
	localparam logic [4:0] T8C_OFS_CNT = 5'h10;
	localparam logic [7:0] T8C_OFS_SCFG = 8'h40;
	// Control register fields
	localparam int T8C_CKS_LSB = 0;
	localparam int T8C_CCLR_LSB = 3;
	localparam int T8C_OVIE_BIT = 5;
	localparam int T8C_CMIEA_BIT = 6;
	localparam int T8C_CMIEB_BIT = 7;
	// Status register fields
	localparam int T8C_FLGB_BIT = 7;
	localparam int T8C_FLGA_BIT = 6;
	localparam int T8C_OVF_BIT = 5;
	// Reset values
	localparam logic [7:0] T8C_CTRL_RST = 8'h00;
	localparam logic [7:0] T8C_TC_RST = 8'hff;
	localparam logic [7:0] T8C_CNT_RST = 8'h00;
	localparam logic [7:0] T8C_SCFG_RST = 8'h00;
	// Prescaler
	localparam int T8C_DIV_W = 11;
	// Clock select codes
	localparam logic [2:0] T8C_CKS_STOP0 = 3'h0;
	localparam logic [2:0] T8C_CKS_DIV_A = 3'h1;
	localparam logic [2:0] T8C_CKS_DIV_B = 3'h2;
	localparam logic [2:0] T8C_CKS_DIV_C = 3'h3;
	localparam logic [2:0] T8C_CKS_STOP1 = 3'h4;
	localparam logic [2:0] T8C_CKS_EXT_R = 3'h5;
	localparam logic [2:0] T8C_CKS_EXT_F = 3'h6;
	localparam logic [2:0] T8C_CKS_EXT_B = 3'h7;
	// Clear codes
	localparam logic [1:0] T8C_CLR_NONE = 2'h0;
	localparam logic [1:0] T8C_CLR_CMA = 2'h1;
	localparam logic [1:0] T8C_CLR_CMB = 2'h2;
	localparam logic [1:0] T8C_CLR_EXT = 2'h3;
	typedef enum logic [1:0] {T8C_BUS_IDLE, T8C_BUS_ACK} t8c_bus_e;
endpackage
`default_nettype wire

// *** core/t8c_chan.sv ***
`default_nettype none
module t8c_chan
	import t8c_pkg::*;
#(
	parameter logic CH = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic [7:0] timer_control,
	input wire logic internal_prescale_pick,
	input wire logic [T8C_DIV_W-1:0] div_cnt,
	input wire logic [T8C_DIV_W-1:0] div_prev,
	// Synchronised external levels
	input wire logic ext_clk_s,
	input wire logic ext_rst_s,
	// Software writes
	input wire logic wr_tca,
	input wire logic wr_tcb,
	input wire logic wr_cnt,
	input wire logic wr_csr,
	input wire logic [7:0] wdat,
	// State
	output logic [7:0] timer_count,
	output logic [7:0] time_constant_a,
	output logic [7:0] time_constant_b,
	output logic [2:0] flags,
	output logic overflow_irq,
	output logic compare_a_irq,
	output logic compare_b_irq
);
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] tca;
		logic [7:0] tcb;
		logic flag_a;
		logic flag_b;
		logic ovf;
		logic eclk_d;
		logic erst_d;
		logic irq_ovf;
		logic irq_cma;
		logic irq_cmb;
	} t8c_chan_s;
	t8c_chan_s st_ff, nxt_st;
	logic [2:0] cks;
	logic [1:0] cclr;
	int tap;
	logic tick, ext_rise, ext_fall, erst_rise, cma, cmb;
	always_comb begin
		cks = timer_control[T8C_CKS_LSB +: 3];
		cclr = timer_control[T8C_CCLR_LSB +: 2];
		// Tap index of divider bit whose falling edge counts
		tap = 0;
		case (cks)
			T8C_CKS_DIV_A: tap = internal_prescale_pick ? 0 : 2; // (R2) (R5)
			T8C_CKS_DIV_B: tap = internal_prescale_pick ? (CH ? 6 : 4) : 5; // (R3) (R6)
			T8C_CKS_DIV_C: tap = internal_prescale_pick ? (CH ? 10 : 7) : 9; // (R4) (R7)
			default: tap = 0;
		endcase
		ext_rise = ext_clk_s & ~st_ff.eclk_d; // (R19)
		ext_fall = ~ext_clk_s & st_ff.eclk_d; // (R19)
		erst_rise = ext_rst_s & ~st_ff.erst_d; // (R19)
		case (cks)
			T8C_CKS_DIV_A, T8C_CKS_DIV_B, T8C_CKS_DIV_C: tick = div_prev[tap] & ~div_cnt[tap]; // (R20)
			T8C_CKS_EXT_R: tick = ext_rise; // (R8)
			T8C_CKS_EXT_F: tick = ext_fall; // (R9)
			T8C_CKS_EXT_B: tick = ext_rise | ext_fall; // (R10)
			default: tick = 1'b0; // (R1)
		endcase
		cma = st_ff.tca == st_ff.cnt;
		cmb = st_ff.tcb == st_ff.cnt;
		nxt_st = st_ff;
		nxt_st.eclk_d = ext_clk_s;
		nxt_st.erst_d = ext_rst_s;
		// Clear-to-zero on write 0; hardware set below wins
		if (wr_csr) begin
			nxt_st.flag_b = st_ff.flag_b & wdat[T8C_FLGB_BIT]; // (R17)
			nxt_st.flag_a = st_ff.flag_a & wdat[T8C_FLGA_BIT]; // (R17)
			nxt_st.ovf = st_ff.ovf & wdat[T8C_OVF_BIT]; // (R17)
		end
		if (cma)
			nxt_st.flag_a = 1'b1; // (R15)
		if (cmb)
			nxt_st.flag_b = 1'b1;
		if (tick) begin
			nxt_st.cnt = st_ff.cnt + 8'h01; // (R18)
			if (st_ff.cnt == 8'hff)
				nxt_st.ovf = 1'b1; // (R18)
		end
		if ((cclr == T8C_CLR_CMA && cma) || (cclr == T8C_CLR_CMB && cmb)) // (R11)
			nxt_st.cnt = 8'h00;
		if (cclr == T8C_CLR_EXT && erst_rise)
			nxt_st.cnt = 8'h00; // (R12)
		if (wr_cnt)
			nxt_st.cnt = wdat;
		if (wr_tca)
			nxt_st.tca = wdat;
		if (wr_tcb)
			nxt_st.tcb = wdat;
		nxt_st.irq_ovf = nxt_st.ovf & timer_control[T8C_OVIE_BIT]; // (R13)
		nxt_st.irq_cma = nxt_st.flag_a & timer_control[T8C_CMIEA_BIT]; // (R14)
		nxt_st.irq_cmb = nxt_st.flag_b & timer_control[T8C_CMIEB_BIT]; // (R16)
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '{cnt: T8C_CNT_RST, tca: T8C_TC_RST, tcb: T8C_TC_RST, default: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign timer_count = st_ff.cnt;
	assign time_constant_a = st_ff.tca;
	assign time_constant_b = st_ff.tcb;
	assign flags = {st_ff.flag_b, st_ff.flag_a, st_ff.ovf};
	assign overflow_irq = st_ff.irq_ovf;
	assign compare_a_irq = st_ff.irq_cma;
	assign compare_b_irq = st_ff.irq_cmb;
endmodule // t8c_chan
`default_nettype wire

// *** core/t8c_top.sv ***
// Operation
// (R1) Select codes 000 and 100 stop the count; counter holds.
// (R2) Channel 0 code 001: divide by 8, or by 2 when pick bit set.
// (R3) Channel 0 code 010: divide by 64, or by 32 when pick bit set.
// (R4) Channel 0 code 011: divide by 1024, or by 256 when pick bit set.
// (R5) Channel 1 code 001: divide by 8, or by 2 when pick bit set.
// (R6) Channel 1 code 010: divide by 64, or by 128 when pick bit set.
// (R7) Channel 1 code 011: divide by 1024, or by 2048 when pick bit set.
// (R8) Code 101 counts external clock rising edges; pick bits ignored.
// (R9) Code 110 counts external clock falling edges.
// (R10) Code 111 counts both external clock edges.
// (R11) Clear field: 00 never, 01 on match A, 10 on match B.
// (R12) Clear code 11 zeroes counter on external reset rising edge.
// (R13) Overflow enable bit gates the overflow request.
// (R14) Match A enable bit gates the match A request.
// (R15) Match A flag sets when constant A equals counter.
// (R16) Match B enable bit gates the match B request.
// (R17) Software clears flags 7..5 by writing 0; writing 1 never sets.
// (R18) 8-bit up-counter wraps to zero and sets overflow flag.
// (R19) External inputs synchronised before edge detection; one action per edge.
// (R20) Prescales from free-running divider; counts on divided clock falling edge.
`default_nettype none
module t8c_top
	import t8c_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// External pins, per channel
	input wire logic [1:0] ext_clk,
	input wire logic [1:0] ext_rst,
	// Interrupt requests, per channel
	output logic [1:0] overflow_irq,
	output logic [1:0] compare_a_irq,
	output logic [1:0] compare_b_irq
);
	typedef struct packed {
		t8c_bus_e bus;
		logic [31:0] rdat;
		logic [1:0][7:0] ctrl;
		logic [7:0] scfg;
		logic [T8C_DIV_W-1:0] div;
		logic [T8C_DIV_W-1:0] div_d;
		logic [1:0] eclk_m;
		logic [1:0] eclk_s;
		logic [1:0] erst_m;
		logic [1:0] erst_s;
	} t8c_top_s;
	t8c_top_s st_ff, nxt_st;
	logic [1:0] wr_tca, wr_tcb, wr_cnt, wr_csr;
	logic [1:0][7:0] cnt_v, tca_v, tcb_v;
	logic [1:0][2:0] flg_v;
	logic [1:0] irq_ovf_v, irq_cma_v, irq_cmb_v;
	logic take, wr_ok, ch;
	logic [4:0] ofs;
	logic [7:0] wb8;
	always_comb begin
		take = wb_cyc_i & wb_stb_i & (st_ff.bus == T8C_BUS_IDLE);
		wr_ok = take & wb_we_i & wb_sel_i[0];
		ch = wb_adr_i[5];
		ofs = wb_adr_i[4:0];
		wb8 = wb_dat_i[7:0];
		wr_tca = '0;
		wr_tcb = '0;
		wr_cnt = '0;
		wr_csr = '0;
		nxt_st = st_ff;
		// Free-running prescale divider
		nxt_st.div = st_ff.div + 1'b1; // (R20)
		nxt_st.div_d = st_ff.div;
		// Two-flop synchronisers
		nxt_st.eclk_m = ext_clk; // (R19)
		nxt_st.eclk_s = st_ff.eclk_m; // (R19)
		nxt_st.erst_m = ext_rst; // (R19)
		nxt_st.erst_s = st_ff.erst_m; // (R19)
		nxt_st.bus = T8C_BUS_IDLE;
		if (take) begin
			nxt_st.bus = T8C_BUS_ACK;
			nxt_st.rdat = 32'h0;
			if (wb_adr_i == T8C_OFS_SCFG) begin
				nxt_st.rdat = {24'h0, st_ff.scfg};
				if (wr_ok)
					nxt_st.scfg = wb8;
			end else if (wb_adr_i[7:6] == 2'b00) begin
				case (ofs)
					T8C_OFS_CTRL: begin
						nxt_st.rdat = {24'h0, st_ff.ctrl[ch]};
						if (wr_ok)
							nxt_st.ctrl[ch] = wb8;
					end
					T8C_OFS_CSR: begin
						nxt_st.rdat = {24'h0, flg_v[ch], 5'h00};
						wr_csr[ch] = wr_ok;
					end
					T8C_OFS_TCA: begin
						nxt_st.rdat = {24'h0, tca_v[ch]};
						wr_tca[ch] = wr_ok;
					end
					T8C_OFS_TCB: begin
						nxt_st.rdat = {24'h0, tcb_v[ch]};
						wr_tcb[ch] = wr_ok;
					end
					T8C_OFS_CNT: begin
						nxt_st.rdat = {24'h0, cnt_v[ch]};
						wr_cnt[ch] = wr_ok;
					end
					default: nxt_st.rdat = 32'h0;
				endcase
			end
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '{bus: T8C_BUS_IDLE, ctrl: {T8C_CTRL_RST, T8C_CTRL_RST}, scfg: T8C_SCFG_RST, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			t8c_chan #(.CH(g == 1)) u_chan (
				.clk(clk),
				.resetn(resetn),
				.timer_control(st_ff.ctrl[g]),
				.internal_prescale_pick(st_ff.scfg[g]),
				.div_cnt(st_ff.div),
				.div_prev(st_ff.div_d),
				.ext_clk_s(st_ff.eclk_s[g]),
				.ext_rst_s(st_ff.erst_s[g]),
				.wr_tca(wr_tca[g]),
				.wr_tcb(wr_tcb[g]),
				.wr_cnt(wr_cnt[g]),
				.wr_csr(wr_csr[g]),
				.wdat(wb8),
				.timer_count(cnt_v[g]),
				.time_constant_a(tca_v[g]),
				.time_constant_b(tcb_v[g]),
				.flags(flg_v[g]),
				.overflow_irq(irq_ovf_v[g]),
				.compare_a_irq(irq_cma_v[g]),
				.compare_b_irq(irq_cmb_v[g])
			);
		end
	endgenerate
	assign wb_ack_o = (st_ff.bus == T8C_BUS_ACK);
	assign wb_dat_o = st_ff.rdat;
	assign overflow_irq = irq_ovf_v;
	assign compare_a_irq = irq_cma_v;
	assign compare_b_irq = irq_cmb_v;
endmodule // t8c_top
`default_nettype wire

// *** tb/t8c_monitor.sv ***
`default_nettype none
module t8c_monitor
	import t8c_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Requests
	input wire logic [1:0] overflow_irq,
	input wire logic [1:0] compare_a_irq,
	input wire logic [1:0] compare_b_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Channel 0 control written with one enable bit low
	sequence ctl_wr(b);
		wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && !wb_dat_i[b];
	endsequence
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	AST_ACK_TIME: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
	AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
	AST_UNMAP: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h80 |-> wb_dat_o == 32'h0) else $error("unmapped");
	AST_OVF_GATE: assert property (ctl_wr(5) |=> !overflow_irq[0]) else $error("ovf unmasked");
	AST_CMA_GATE: assert property (ctl_wr(6) |=> !compare_a_irq[0]) else $error("match a unmasked");
	AST_CMB_GATE: assert property (ctl_wr(7) |=> !compare_b_irq[0]) else $error("match b unmasked");
endmodule // t8c_monitor
bind t8c_top t8c_monitor mon (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .overflow_irq, .compare_a_irq, .compare_b_irq);
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb
	import t8c_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic resetn = 0;
	logic cyc = 0;
	logic we = 0;
	logic ack;
	logic [7:0] adr = 0;
	logic [7:0] rd;
	logic [7:0] c0;
	logic [31:0] wdat = 0;
	logic [31:0] rdat;
	logic [1:0] xclk = 0;
	logic [1:0] xrst = 0;
	logic [1:0] ovf_irq;
	logic [3:0] sel = 4'hf;
	logic [3:0] sel_n = 4'hf;
	logic [1:0] cma;
	logic [1:0] cmb;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	// Divisor by channel, pick bit and select code; 0 means stopped
	int nd[20] = '{0, 8, 64, 1024, 0, 0, 2, 32, 256, 0, 0, 8, 64, 1024, 0, 0, 2, 128, 2048, 0};
	initial forever #20 clk = ~clk;
	t8c_top dut (.clk, .resetn, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk(xclk), .ext_rst(xrst),
		.overflow_irq(ovf_irq), .compare_a_irq(cma), .compare_b_irq(cmb));
	task automatic conclude();
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures++;
			conclude();
		end
	end
	task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= a;
		wdat <= 32'(d);
		sel <= sel_n;
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat[7:0];
		cyc <= 0;
	endtask
	// Toggles a pin n times, slow enough for the three-flop input path
	task automatic edges(int ch, int n, bit r);
		repeat (n) begin
			if (r)
				xrst[ch] <= ~xrst[ch];
			else
				xclk[ch] <= ~xclk[ch];
			tick(4);
		end
	endtask
	task automatic t_regs();
		bus(0, 8'h00, 0);
		chk("ctrl", rd, T8C_CTRL_RST);
		bus(0, 8'h2c, 0);
		chk("tcb", rd, T8C_TC_RST);
		bus(0, 8'h40, 0);
		chk("scfg", rd, T8C_SCFG_RST);
		bus(1, 8'h80, 8'h5a);
		bus(0, 8'h80, 0);
		chk("unmap", rd, 8'h00);
		// Low byte lane off: the write must be dropped
		sel_n = 4'he;
		bus(1, 8'h00, 8'h5a);
		sel_n = 4'hf;
		bus(0, 8'h00, 0);
		chk("sel", rd, T8C_CTRL_RST);
	endtask
	// Two reads exactly 2N cycles apart see two counts whatever the phase
	task automatic t_presc();
		for (int i = 0; i < 20; i++) begin
			bus(1, 8'h40, 8'((i % 10 / 5) << (i / 10)));
			bus(1, 8'(i / 10 * 32), 8'(i % 5));
			bus(0, 8'(i / 10 * 32 + 16), 0);
			c0 = rd;
			tick((nd[i] ? 2 * nd[i] : 64) - 3);
			bus(0, 8'(i / 10 * 32 + 16), 0);
			chk("presc", rd - c0, nd[i] ? 8'h2 : 8'h0);
		end
	endtask
	task automatic t_ext();
		bus(1, 8'h40, 8'h3);
		for (int i = 0; i < 6; i++) begin
			bus(1, 8'(i / 3 * 32), 8'(5 + i % 3));
			bus(1, 8'(i / 3 * 32 + 16), 0);
			edges(i / 3, 6, 0);
			bus(0, 8'(i / 3 * 32 + 16), 0);
			chk("ext", rd, i % 3 == 2 ? 8'h6 : 8'h3);
		end
	endtask
	task automatic t_clr();
		bus(1, 8'h08, 8'h05);
		bus(1, 8'h0c, 8'h02);
		bus(1, 8'h00, 8'h4f);
		bus(1, 8'h10, 0);
		edges(0, 8, 0);
		bus(0, 8'h10, 0);
		chk("clra", rd, 8'h3);
		chk("cma", 8'(cma[0]), 8'h1);
		bus(1, 8'h04, 8'h00);
		bus(1, 8'h04, 8'he0);
		bus(0, 8'h04, 0);
		chk("flags", rd, 8'h0);
		bus(1, 8'h00, 8'h97);
		bus(1, 8'h10, 0);
		edges(0, 8, 0);
		bus(0, 8'h10, 0);
		chk("clrb", rd, 8'h0);
		chk("cmb", 8'(cmb[0]), 8'h1);
		bus(1, 8'h00, 8'h1f);
		bus(1, 8'h10, 0);
		edges(0, 4, 0);
		bus(0, 8'h10, 0);
		chk("noclr", rd, 8'h4);
		edges(0, 2, 1);
		bus(0, 8'h10, 0);
		chk("xrst", rd, 8'h0);
	endtask
	task automatic t_ovf();
		bus(1, 8'h00, 8'h27);
		bus(1, 8'h10, 8'hfe);
		edges(0, 2, 0);
		bus(0, 8'h04, 0);
		chk("ovf", rd & 8'h20, 8'h20);
		chk("ovf_irq", 8'(ovf_irq[0]), 8'h1);
		bus(1, 8'h00, 8'h07);
		tick(2);
		chk("mask", 8'(ovf_irq[0]), 8'h0);
	endtask
	initial begin
		tick(8);
		resetn <= 1;
		t_regs();
		t_presc();
		t_ext();
		t_clr();
		t_ovf();
		conclude();
	end
endmodule // tb
`default_nettype wire
